// File: rtl/adc_dev.sv
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "adc_link_cfg.svh"
module adc_dev
    import adc_link_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // Link
    adc_link_if.device                link,
    // Converter core
    input  wire logic [`RES_BITS-1:0] result_a_i,
    input  wire logic [`RES_BITS-1:0] result_b_i,
    output logic                      conv_start_o,
    output logic                      channel_pair_o,
    output logic                      pseudo_diff_o,
    output logic                      bias_on_o,
    output logic                      deep_sleep_flag_o,
    output logic                      ref_off_o,
    output logic [`DAC_BITS-1:0]      dac_value_o
);
    localparam int RST_CYC   = `CYC_UP(`RESET_NS);
    localparam int DEEP_CYC  = `CYC_DN(`DEEP_ENTRY_NS);
    localparam int WAKE_CYC  = `CYC_UP(`DEEP_WAKE_NS);
    localparam int LIGHT_CYC = `CYC_DN(`LIGHT_OFF_NS);

    logic [1:0] s_clk, s_trg, s_rd, s_sdi, s_m0, s_m1;
    logic       clk_d, trg_d, rd_d;
    logic       fall, trg_rise, rd_rise, alive, apply;
    logic [`CMD_BITS-1:0] next_cmd, cmd_sh;
    logic [5:0] acc_cnt;
    logic       acc_on, wr_acc, rd_acc, wr_pend, rd_pend;
    logic [1:0] cmd_c;
    logic       deep_sleep_flag, nap, auto_sleep_after_conversion, rp;
    logic       special_dual_read_enable;
    logic [`DAC_BITS-1:0] dac;
    logic [7:0] rst_cnt;
    logic       in_reset;
    pwr_state_e pwr;
    logic [7:0] pwr_cnt;
    logic       wake_link, asleep;
    conv_state_e cv;
    logic [4:0] cv_cnt, cv_len;
    logic       auto_pair, pair, pseudo;
    logic [2:0] leg_cnt;
    logic       leg_lvl, leg_ok;
    logic [`RES_BITS-1:0] res_a, res_b;
    logic       tag_a;
    logic       next_b;
    logic [`FRAME_BITS-1:0] sh_a, sh_b;
    logic       oe_a, oe_b;

    function automatic logic [`WORD_BITS-1:0] fmt(input logic adc, input logic ch,
                                                  input logic [`RES_BITS-1:0] r);
        fmt = {ch & s_m0[1], adc & s_m1[1], r, 2'h0};
    endfunction

    // Every link input crosses into clk_i before use
    always_ff @(posedge clk_i) begin
        s_clk <= {s_clk[0], link.link_clk};
        s_trg <= {s_trg[0], link.conversion_trigger};
        s_rd  <= {s_rd[0], link.read_strobe};
        s_sdi <= {s_sdi[0], link.serial_command_input};
        s_m0  <= {s_m0[0], link.channel_auto_select_pin};
        s_m1  <= {s_m1[0], link.single_output_select_pin};
        clk_d <= s_clk[1];
        trg_d <= s_trg[1];
        rd_d  <= s_rd[1];
    end

    assign fall     = clk_d & ~s_clk[1];
    assign trg_rise = ~trg_d & s_trg[1];
    assign rd_rise  = ~rd_d & s_rd[1];
    assign alive    = rst_b_i & ~in_reset;
    assign next_cmd = {cmd_sh[`CMD_BITS-2:0], s_sdi[1]};
    assign apply    = fall & acc_on & (acc_cnt == `APPLY_EDGE);

    // Command-driven reset holds everything, the serial port included
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            in_reset <= 1'b0;
            rst_cnt  <= 8'h0;
        end else if (in_reset) begin
            rst_cnt <= rst_cnt - 8'h1;
            if (rst_cnt == 8'h1) begin
                in_reset <= 1'b0;
            end
        end else if (apply && !wr_acc && !rd_acc && next_cmd[`CMD_A] == `ACT_RESET) begin
            in_reset <= 1'b1;
            rst_cnt  <= 8'(RST_CYC);
        end
    end

    // Access framing and command shift
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            acc_on  <= 1'b0;
            acc_cnt <= 6'h0;
            cmd_sh  <= '0;
        end else if (rd_rise) begin
            acc_on  <= 1'b1;
            acc_cnt <= 6'h0;
        end else if (fall && acc_on) begin
            cmd_sh  <= next_cmd;
            acc_cnt <= acc_cnt + 6'h1;
            if (acc_cnt == 6'(`FRAME_BITS - 1)) begin
                acc_on <= 1'b0;
            end
        end
    end

    // Feature bits and the reference DAC
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            cmd_c                       <= 2'h0;
            deep_sleep_flag             <= 1'b0;
            nap                         <= 1'b0;
            auto_sleep_after_conversion <= 1'b0;
            rp                          <= 1'b0;
            special_dual_read_enable    <= 1'b0;
            dac                         <= `DAC_RESET;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_acc  <= 1'b0;
            rd_acc  <= 1'b0;
        end else if (rd_rise) begin
            wr_acc  <= wr_pend;
            rd_acc  <= rd_pend;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else if (apply && wr_acc) begin
            dac <= next_cmd[`CMD_DAC];
        end else if (apply && !rd_acc) begin
            cmd_c <= next_cmd[`CMD_C];
            if (next_cmd[`CMD_P] == `UPD_CODE) begin
                deep_sleep_flag             <= next_cmd[`CMD_DP];
                nap                         <= next_cmd[`CMD_NAP];
                auto_sleep_after_conversion <= next_cmd[`CMD_AN];
                rp                          <= next_cmd[`CMD_RP];
                special_dual_read_enable    <= next_cmd[`CMD_S4];
                wr_pend <= next_cmd[`CMD_A] == `ACT_DAC_WR;
                rd_pend <= next_cmd[`CMD_A] == `ACT_DAC_RD;
            end
        end
    end

    // Power-down sequencing
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            pwr       <= PWR_RUN;
            pwr_cnt   <= 8'h0;
            wake_link <= 1'b0;
            bias_on_o <= 1'b1;
        end else begin
            case (pwr)
                PWR_RUN: begin
                    bias_on_o <= ~asleep;
                    if (deep_sleep_flag) begin
                        pwr     <= PWR_DEEP;
                        pwr_cnt <= 8'(DEEP_CYC);
                    end else if (nap) begin
                        pwr     <= PWR_LIGHT;
                        pwr_cnt <= 8'(LIGHT_CYC);
                    end
                end
                PWR_DEEP, PWR_LIGHT: begin
                    if (pwr_cnt > 8'h1) begin
                        pwr_cnt <= pwr_cnt - 8'h1;
                    end else begin
                        bias_on_o <= 1'b0;
                    end
                    if ((pwr == PWR_DEEP) ? !deep_sleep_flag : !nap) begin
                        pwr       <= PWR_WAKE;
                        wake_link <= pwr == PWR_LIGHT;
                        pwr_cnt   <= (pwr == PWR_LIGHT) ? 8'(`LIGHT_RESUME) : 8'(WAKE_CYC);
                    end
                end
                PWR_WAKE: begin
                    // Light sleep counts link clocks, deep sleep counts time
                    if (!wake_link || fall) begin
                        pwr_cnt <= pwr_cnt - 8'h1;
                        if (pwr_cnt == 8'h1) begin
                            pwr       <= PWR_RUN;
                            bias_on_o <= 1'b1;
                        end
                    end
                end
                default: pwr <= PWR_RUN;
            endcase
        end
    end

    // Conversion sequencing
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            cv           <= CV_IDLE;
            cv_cnt       <= 5'h0;
            cv_len       <= `CONV_EDGES;
            asleep       <= 1'b0;
            auto_pair    <= 1'b0;
            pair         <= 1'b0;
            pseudo       <= 1'b0;
            res_a        <= '0;
            res_b        <= '0;
            tag_a        <= 1'b0;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            case (cv)
                CV_IDLE: begin
                    if (trg_rise && pwr == PWR_RUN) begin
                        cv     <= asleep ? CV_DELAY : CV_RUN;
                        cv_len <= asleep ? `AUTONAP_CYCLE - `AUTONAP_DELAY : `CONV_EDGES;
                        cv_cnt <= 5'h0;
                        asleep <= 1'b0;
                        conv_start_o <= ~asleep;
                        pair   <= s_m0[1] ? auto_pair : cmd_c[0];
                        pseudo <= ~s_m0[1] & cmd_c[1];
                    end
                end
                CV_DELAY: begin
                    if (fall) begin
                        cv_cnt <= cv_cnt + 5'h1;
                        if (cv_cnt == `AUTONAP_DELAY - 5'h1) begin
                            cv           <= CV_RUN;
                            cv_cnt       <= 5'h0;
                            conv_start_o <= 1'b1;
                        end
                    end
                end
                CV_RUN: begin
                    // The fourth edge's own sample must match as well
                    if (!s_m0[1] && leg_ok && s_sdi[1] == leg_lvl && fall
                        && leg_cnt == `LEGACY_EDGES - 3'h1) begin
                        pair   <= leg_lvl;
                        pseudo <= 1'b0;
                    end
                    if (fall) begin
                        cv_cnt <= cv_cnt + 5'h1;
                        if (cv_cnt == cv_len - 5'h1) begin
                            cv        <= CV_IDLE;
                            res_a     <= result_a_i;
                            res_b     <= result_b_i;
                            tag_a     <= pair;
                            asleep    <= auto_sleep_after_conversion;
                            auto_pair <= s_m0[1] ? ~auto_pair : auto_pair;
                        end
                    end
                end
                default: cv <= CV_IDLE;
            endcase
            if (deep_sleep_flag || nap) begin
                cv <= CV_IDLE;
            end
        end
    end

    // Legacy pair selection watches the first edges after the trigger
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            leg_cnt <= 3'h0;
            leg_lvl <= 1'b0;
            leg_ok  <= 1'b0;
        end else if (trg_rise) begin
            leg_cnt <= 3'h0;
            leg_lvl <= s_sdi[1];
            leg_ok  <= 1'b1;
        end else if (fall && leg_cnt != `LEGACY_EDGES) begin
            leg_cnt <= leg_cnt + 3'h1;
            if (s_sdi[1] != leg_lvl) begin
                leg_ok <= 1'b0;
            end
        end
    end

    // Readout shift registers
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            sh_a   <= '0;
            sh_b   <= '0;
            oe_a   <= 1'b0;
            oe_b   <= 1'b0;
            next_b <= 1'b0;
        end else if (rd_rise) begin
            oe_a <= 1'b1;
            sh_b <= {fmt(1'b1, tag_a, res_b), 16'h0};
            if (rd_pend) begin
                sh_a <= {4'h0, dac, 2'h0, 16'h0};
                oe_b <= ~s_m1[1];
            end else if (!s_m1[1]) begin
                sh_a <= {fmt(1'b0, tag_a, res_a), 16'h0};
                oe_b <= 1'b1;
            end else if (special_dual_read_enable) begin
                sh_a <= {fmt(1'b0, tag_a, res_a), fmt(1'b1, tag_a, res_b)};
                oe_b <= ~s_m0[1];
            end else begin
                sh_a   <= {next_b ? fmt(1'b1, tag_a, res_b) : fmt(1'b0, tag_a, res_a), 16'h0};
                next_b <= ~next_b;
                oe_b   <= 1'b0;
            end
        end else if (fall && acc_on) begin
            sh_a <= {sh_a[`FRAME_BITS-2:0], 1'b0};
            sh_b <= {sh_b[`FRAME_BITS-2:0], 1'b0};
            if (acc_cnt == 6'(`FRAME_BITS - 1)) begin
                oe_a <= 1'b0;
                oe_b <= 1'b0;
            end
        end
    end

    // Core-facing copies
    always_ff @(posedge clk_i) begin
        if (!alive) begin
            channel_pair_o    <= 1'b0;
            pseudo_diff_o     <= 1'b0;
            deep_sleep_flag_o <= 1'b0;
            ref_off_o         <= 1'b0;
            dac_value_o       <= `DAC_RESET;
        end else begin
            channel_pair_o    <= pair;
            pseudo_diff_o     <= pseudo;
            deep_sleep_flag_o <= pwr == PWR_DEEP;
            ref_off_o         <= rp;
            dac_value_o       <= dac;
        end
    end

    assign link.serial_out_first     = sh_a[`FRAME_BITS-1];
    assign link.serial_out_first_oe  = oe_a;
    assign link.serial_out_second    = sh_b[`FRAME_BITS-1];
    assign link.serial_out_second_oe = oe_b;
endmodule

// File: rtl/adc_host.sv
`timescale 1ns/100ps
`include "adc_link_cfg.svh"
module adc_host
    import adc_link_pkg::*;
#(
    parameter int HALF_DIV = 8
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Link
    adc_link_if.host         link,
    // Software port
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o
);
    host_state_e st;
    logic [1:0]  s_a, s_b;
    logic [7:0]  div;
    logic [5:0]  nbits, bit_cnt;
    logic [`CMD_BITS-1:0] cmd, tx;
    logic [31:0] rx_a, rx_b;
    logic [1:0]  pins;
    logic        lclk, strobe, tick;

    assign tick = div == 8'(HALF_DIV - 1);

    // Floating outputs read as zero
    always_ff @(posedge clk_i) begin
        s_a <= {s_a[0], link.serial_out_first & link.serial_out_first_oe};
        s_b <= {s_b[0], link.serial_out_second & link.serial_out_second_oe};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pins <= 2'h0;
        end else if (wr_i && addr_i == `HREG_CTRL) begin
            pins <= wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st      <= H_IDLE;
            div     <= 8'h0;
            lclk    <= 1'b0;
            strobe  <= 1'b0;
            nbits   <= 6'h0;
            bit_cnt <= 6'h0;
            cmd     <= '0;
            tx      <= '0;
            rx_a    <= '0;
            rx_b    <= '0;
        end else begin
            div <= tick ? 8'h0 : div + 8'h1;
            case (st)
                H_IDLE: begin
                    if (wr_i && addr_i == `HREG_CMD) begin
                        cmd     <= wdata_i[`CMD_BITS-1:0];
                        tx      <= wdata_i[`CMD_BITS-1:0];
                        nbits   <= wdata_i[`HCMD_LONG] ? 6'(`FRAME_BITS) : 6'(`WORD_BITS);
                        strobe  <= 1'b1;
                        div     <= 8'h0;
                        bit_cnt <= 6'h0;
                        st      <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    if (tick) begin
                        strobe <= 1'b0;
                        st     <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick) begin
                        if (!lclk && bit_cnt != nbits) begin
                            lclk    <= 1'b1;
                            bit_cnt <= bit_cnt + 6'h1;
                            rx_a    <= {rx_a[30:0], s_a[1]};
                            rx_b    <= {rx_b[30:0], s_b[1]};
                            // Shift on rising edges so the bit is steady at the fall
                            if (bit_cnt != 6'h0) begin
                                tx <= {tx[`CMD_BITS-2:0], tx[0]};
                            end
                        end else if (lclk) begin
                            lclk <= 1'b0;
                        end else begin
                            st <= H_IDLE;
                        end
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            case (addr_i)
                `HREG_CTRL: rdata_o <= {23'h0, st != H_IDLE, 6'h0, pins};
                `HREG_CMD:  rdata_o <= {20'h0, cmd};
                `HREG_RXA:  rdata_o <= rx_a;
                default:    rdata_o <= rx_b;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    assign link.link_clk                 = lclk;
    assign link.conversion_trigger       = strobe;
    assign link.read_strobe              = strobe;
    assign link.serial_command_input     = tx[`CMD_BITS-1];
    assign link.channel_auto_select_pin  = pins[0];
    assign link.single_output_select_pin = pins[1];
endmodule

// File: rtl/adc_link_cfg.svh
// Overview of operation
// - Special read: one strobe, both results, single-output modes
// - Special manual read drives both outputs
// - Special automatic read: both results on first
// - No special read in dual-output modes
// - Manual dual: pseudo-differential via channel bits
// - Manual single pseudo-diff: second output floats
// - No pseudo-differential in automatic cycling
// - Host writes DAC: command, then value
// - DAC readback: zeros, value, zeros on first
// - Readback ignores input, second keeps B data
// - DAC value starts at 3ff
// - Sleep modes begin at twelfth falling edge
// - Sleep ends on clear; command unchanged
// - Deep or light sleep aborts conversion
// - Deep: entry within 2us, wake 1us
// - Light: bias off 200ns, resume 3 clocks
// - Auto sleep: trigger wakes, 19 clock cycle
// - Reset command resets all, 500ns recovery
// - Static input selects channel pair, legacy
// - Host holds input static in legacy cycling; adc_host shifts out the command word instead
// - Mode pins pick selection and outputs
// - Command features apply at twelfth clock
`ifndef ADC_LINK_CFG_SVH
`define ADC_LINK_CFG_SVH

`define CLK_MHZ        100
`define CYC_UP(ns)     (((ns) * `CLK_MHZ + 999) / 1000)
`define CYC_DN(ns)     (((ns) * `CLK_MHZ) / 1000)

`define CMD_BITS       12
`define WORD_BITS      16
`define FRAME_BITS     32
`define RES_BITS       12
`define DAC_BITS       10
`define DAC_RESET      10'h3ff

`define CMD_C          11:10
`define CMD_PSEUDO     11
`define CMD_PAIR       10
`define CMD_P          9:8
`define CMD_DP         7
`define CMD_NAP        6
`define CMD_AN         5
`define CMD_RP         4
`define CMD_S4         3
`define CMD_A          2:0
`define CMD_DAC        9:0

`define UPD_CODE       2'h1
`define ACT_DAC_WR     3'h1
`define ACT_DAC_RD     3'h3
`define ACT_RESET      3'h5

`define APPLY_EDGE     6'h0b
`define LEGACY_EDGES   3'h4
`define CONV_EDGES     5'h10
`define AUTONAP_DELAY  5'h06
`define AUTONAP_CYCLE  5'h13
`define LIGHT_RESUME   2'h3

`define DEEP_ENTRY_NS  2000
`define DEEP_WAKE_NS   1000
`define LIGHT_OFF_NS   200
`define RESET_NS       500

`define HREG_CTRL      2'h0
`define HREG_CMD       2'h1
`define HREG_RXA       2'h2
`define HREG_RXB       2'h3
`define HCMD_LONG      12
`define HCTRL_BUSY     8

`endif

// File: rtl/adc_link_if.sv
`timescale 1ns/100ps
interface adc_link_if;
    logic link_clk;
    logic conversion_trigger;
    logic read_strobe;
    logic serial_command_input;
    logic channel_auto_select_pin;
    logic single_output_select_pin;
    logic serial_out_first;
    logic serial_out_first_oe;
    logic serial_out_second;
    logic serial_out_second_oe;
    modport device (
        input  link_clk, conversion_trigger, read_strobe, serial_command_input,
        input  channel_auto_select_pin, single_output_select_pin,
        output serial_out_first, serial_out_first_oe,
        output serial_out_second, serial_out_second_oe
    );
    modport host (
        output link_clk, conversion_trigger, read_strobe, serial_command_input,
        output channel_auto_select_pin, single_output_select_pin,
        input  serial_out_first, serial_out_first_oe,
        input  serial_out_second, serial_out_second_oe
    );
endinterface

// File: rtl/adc_link_pkg.sv
package adc_link_pkg;
    typedef enum logic [3:0] {
        PWR_RUN   = 4'h1,
        PWR_DEEP  = 4'h2,
        PWR_LIGHT = 4'h4,
        PWR_WAKE  = 4'h8
    } pwr_state_e;
    typedef enum logic [2:0] {
        CV_IDLE  = 3'h1,
        CV_DELAY = 3'h2,
        CV_RUN   = 3'h4
    } conv_state_e;
    typedef enum logic [2:0] {
        H_IDLE   = 3'h1,
        H_STROBE = 3'h2,
        H_SHIFT  = 3'h4
    } host_state_e;
endpackage

// File: tb/adc_link_checker.sv
`timescale 1ns/100ps
module adc_link_checker #(
    parameter int HALF_DIV = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Link
    input wire logic link_clk,
    input wire logic conversion_trigger,
    input wire logic read_strobe,
    input wire logic channel_auto_select_pin,
    input wire logic single_output_select_pin,
    input wire logic serial_out_first,
    input wire logic serial_out_first_oe,
    input wire logic serial_out_second_oe
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [7:0] high_run;
    logic [3:0] since_fall;
    logic [9:0] oe_run;
    logic       link_q;
    // Counters stand in for long repetitions
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !link_clk) high_run <= 8'h00;
        else if (high_run != 8'hff) high_run <= high_run + 8'h01;
    end
    always_ff @(posedge clk_i) begin
        link_q <= link_clk;
        if (!rst_b_i || (link_q && !link_clk)) since_fall <= 4'h0;
        else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
    end
    // Counts link clock falls of one access; a short frame keeps the output driven
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !serial_out_first_oe || $rose(read_strobe)) oe_run <= 10'h000;
        else if (link_q && !link_clk && oe_run != 10'h3ff) oe_run <= oe_run + 10'h001;
    end
    sequence strobe_seen;
        $rose(read_strobe);
    endsequence
    sequence out_driven;
        ##[1:10] serial_out_first_oe;
    endsequence
    chk_strobe_tied: assert property (conversion_trigger == read_strobe)
        else $error("trigger and read strobe differ");
    chk_out_after_strobe: assert property (strobe_seen |-> out_driven)
        else $error("first output not driven after strobe");
    chk_shift_on_fall: assert property (serial_out_first_oe && $past(serial_out_first_oe)
        && $changed(serial_out_first) |-> since_fall <= 4'h7)
        else $error("first output changed away from a link clock fall");
    chk_single_auto_float: assert property ($rose(read_strobe) && channel_auto_select_pin
        && single_output_select_pin |-> ##4 !serial_out_second_oe)
        else $error("second output driven in automatic single mode");
    chk_dual_both_out: assert property (!single_output_select_pin
        && serial_out_first_oe |-> serial_out_second_oe)
        else $error("second output idle in dual mode");
    chk_clk_idle_strobe: assert property (strobe_seen |-> !link_clk [*8])
        else $error("link clock moved during strobe");
    chk_half_period: assert property ($fell(link_clk) |-> high_run == HALF_DIV)
        else $error("link clock high phase wrong");
    chk_frame_bound: assert property (oe_run == 10'h020 |-> ##[1:6] !serial_out_first_oe)
        else $error("first output driven too long");
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "adc_link_cfg.svh"
module testbench;
    localparam int HALF_DIV = 8;
    logic        clk_i;
    logic        rst_b_i;
    logic [1:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic [11:0] result_a_i;
    logic [11:0] result_b_i;
    logic        bias_on_o;
    logic        deep_sleep_flag_o;
    logic [9:0]  dac_value_o;
    logic [31:0] rv;
    int          error_cnt;
    int          checks_done;
    adc_link_if link ();
    adc_dev adc_dev_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
        .result_a_i(result_a_i), .result_b_i(result_b_i), .conv_start_o(),
        .channel_pair_o(), .pseudo_diff_o(), .bias_on_o(bias_on_o),
        .deep_sleep_flag_o(deep_sleep_flag_o), .ref_off_o(), .dac_value_o(dac_value_o));
    adc_host #(.HALF_DIV(HALF_DIV)) adc_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .link(link), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o));
    adc_link_checker #(.HALF_DIV(HALF_DIV)) adc_link_checker_inst (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .link_clk(link.link_clk),
        .conversion_trigger(link.conversion_trigger), .read_strobe(link.read_strobe),
        .channel_auto_select_pin(link.channel_auto_select_pin),
        .single_output_select_pin(link.single_output_select_pin),
        .serial_out_first(link.serial_out_first),
        .serial_out_first_oe(link.serial_out_first_oe),
        .serial_out_second_oe(link.serial_out_second_oe));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // One link access; busy is polled with a bound so a hang ends the run
    task automatic access(input logic [12:0] word);
        int n;
        wr(2'h1, {19'h0, word});
        repeat (4) @(posedge clk_i);
        rv = 32'h100;
        for (n = 0; n < 2000 && rv[`HCTRL_BUSY] !== 1'b0; n++) rd(2'h0, rv);
        if (rv[`HCTRL_BUSY] !== 1'b0) begin
            error_cnt++;
            final_report();
        end
    endtask
    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_b_i = 1'b0;
        addr_i = 2'h0;
        wdata_i = 32'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        result_a_i = 12'h5a3;
        result_b_i = 12'h2c6;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({22'h0, dac_value_o}, 32'h3ff);
        check({30'h0, deep_sleep_flag_o, bias_on_o}, 32'h1);
        $display("test reset done");
        wr(2'h0, 32'h0);
        access(13'h000);
        access(13'h000);
        rd(2'h2, rv);
        check({16'h0, rv[15:0]}, 32'h168c);
        rd(2'h3, rv);
        check({16'h0, rv[15:0]}, 32'h0b18);
        $display("test dual readout done");
        access(13'h101);
        access(13'h155);
        check({22'h0, dac_value_o}, 32'h155);
        access(13'h103);
        // Sleep request in the readback word must be ignored
        access(13'h180);
        rd(2'h2, rv);
        check({16'h0, rv[15:0]}, 32'h0554);
        rd(2'h3, rv);
        check({16'h0, rv[15:0]}, 32'h0b18);
        repeat (250) @(posedge clk_i);
        check({31'h0, deep_sleep_flag_o}, 32'h0);
        $display("test dac access done");
        access(13'h180);
        repeat (250) @(posedge clk_i);
        check({30'h0, deep_sleep_flag_o, bias_on_o}, 32'h2);
        check({22'h0, dac_value_o}, 32'h155);
        access(13'h100);
        repeat (150) @(posedge clk_i);
        check({30'h0, deep_sleep_flag_o, bias_on_o}, 32'h1);
        access(13'h140);
        repeat (30) @(posedge clk_i);
        check({30'h0, deep_sleep_flag_o, bias_on_o}, 32'h0);
        access(13'h100);
        repeat (80) @(posedge clk_i);
        check({30'h0, deep_sleep_flag_o, bias_on_o}, 32'h1);
        $display("test sleep done");
        wr(2'h0, 32'h3);
        access(13'h1108);
        access(13'h1000);
        rd(2'h2, rv);
        check(rv & 32'h7fff7fff, 32'h168c4b18);
        rd(2'h3, rv);
        check(rv, 32'h0);
        wr(2'h0, 32'h2);
        access(13'h1000);
        rd(2'h2, rv);
        check(rv, 32'h168c4b18);
        rd(2'h3, rv);
        check(rv, 32'h4b180000);
        wr(2'h0, 32'h0);
        $display("test special read done");
        access(13'h105);
        repeat (100) @(posedge clk_i);
        check({22'h0, dac_value_o}, 32'h3ff);
        $display("test command reset done");
        final_report();
    end
endmodule
